/* plr_pkg.sv */
// Package for the second-loop pump, lock and filter register slice.
// Assumes a 20 MHz aclk and AXI4-Lite register access.
package plr_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [11:0] PLR_IDX_PUMP_CTRL = 12'h169;
  localparam logic [11:0] PLR_IDX_LOCK_HIGH = 12'h16A;
  localparam logic [11:0] PLR_IDX_LOCK_LOW = 12'h16B;
  localparam logic [11:0] PLR_IDX_FILTER_RES = 12'h16C;
  localparam logic [11:0] PLR_IDX_IRQ_STATUS = 12'h170;
  localparam logic [11:0] PLR_IDX_IRQ_MASK = 12'h171;
  localparam logic [11:0] PLR_IDX_LOCK_STATE = 12'h172;

  // Field positions
  localparam int PLR_POS_WINDOW = 5;
  localparam int PLR_POS_GAIN = 3;
  localparam int PLR_POS_POLARITY = 2;
  localparam int PLR_POS_FLOAT = 1;
  localparam int PLR_POS_FIXED = 0;
  localparam int PLR_POS_REQ_EN = 6;
  localparam int PLR_POS_RES_FOUR = 3;
  localparam int PLR_POS_RES_THREE = 0;

  // Write masks of the writable bits
  localparam logic [7:0] PLR_MASK_PUMP_CTRL = 8'h7F;
  localparam logic [7:0] PLR_MASK_LOCK_HIGH = 8'h7F;
  localparam logic [7:0] PLR_MASK_LOCK_LOW = 8'hFF;
  localparam logic [7:0] PLR_MASK_FILTER_RES = 8'h3F;
  localparam logic [7:0] PLR_MASK_IRQ = 8'h07;

  // Reset values
  localparam logic [7:0] PLR_RST_PUMP_CTRL = 8'h59;
  localparam logic [7:0] PLR_RST_LOCK_HIGH = 8'h20;
  localparam logic [7:0] PLR_RST_LOCK_LOW = 8'h00;
  localparam logic [7:0] PLR_RST_FILTER_RES = 8'h00;
  localparam logic [7:0] PLR_RST_IRQ_MASK = 8'h00;

  // Frame-reference source codes
  localparam logic [1:0] PLR_SRC_PULSER = 2'h2;
  localparam logic [1:0] PLR_SRC_CONTINUOUS = 2'h3;

  // Status bit positions
  localparam int PLR_IRQ_LOCKED = 0;
  localparam int PLR_IRQ_UNLOCKED = 1;
  localparam int PLR_IRQ_REQUEST = 2;

  // Pin input synchroniser depth
  localparam int PLR_SYNC_STAGES = 3;

  localparam logic [1:0] PLR_RESP_OKAY = 2'h0;
  localparam logic [1:0] PLR_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [1:0] window_width;
    logic [1:0] pump_gain;
    logic pump_polarity;
    logic pump_float;
  } plr_pump_type;

  typedef struct packed {
    logic [2:0] filter_res_four;
    logic [2:0] filter_res_three;
  } plr_filter_type;

  function automatic logic [11:0] plr_index(input logic [13:0] byte_addr);
    plr_index = byte_addr[13:2];
  endfunction

endpackage

/* plr_pin_sync.sv */
// Three-stage synchroniser for one pin input with agreement filter.
// Assumes the pin is asynchronous to aclk.
`timescale 1ns/100ps
module plr_pin_sync
  import plr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin_in,
  output logic level_q
);

  logic [PLR_SYNC_STAGES-1:0] stage_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage_q <= '0;
    end else begin
      stage_q <= {stage_q[PLR_SYNC_STAGES-2:0], pin_in};
    end
  end

  // Change counts once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_q <= 1'b0;
    end else if (stage_q[1] == stage_q[2]) begin
      level_q <= stage_q[2];
    end
  end

endmodule // plr_pin_sync

/* plr_lock_detect.sv */
// Digital lock qualifier for the second loop.
// Assumes one compare strobe per reference/feedback comparison, on aclk.
`timescale 1ns/100ps
module plr_lock_detect
  import plr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic compare_strobe,
  input wire logic in_window,
  input wire logic [13:0] qualify_count,
  output logic locked_q,
  output logic [13:0] count_q
);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= 14'h0000;
    end else if (compare_strobe) begin
      if (!in_window) begin
        count_q <= 14'h0000;
      end else if (count_q != 14'h3FFF) begin
        count_q <= count_q + 14'h0001; // [RULE10]
      end
    end
  end

  // Zero count is invalid and never qualifies
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      locked_q <= 1'b0;
    end else if (compare_strobe) begin
      // Widened compare so a saturated count still qualifies
      locked_q <= in_window && (qualify_count != 14'h0000) &&
                  (({1'b0, count_q} + 15'h0001) >= {1'b0, qualify_count}); // [RULE6]
    end
  end

endmodule // plr_lock_detect

/* plr_regs.sv */
// Notes on behaviour
// RULE1 - Polarity bit: 0 negative-slope oscillator, 1 positive-slope; defaults to 0.
// RULE2 - Float bit 1 puts the pump output in high impedance; defaults to 0.
// RULE3 - Software always writes 1 to pump control bit 0; resets to 1.
// RULE4 - With request enable set, the sync pin forces source select to 3.
// RULE5 - Software enables the pulser and programs source select 2 first.
// RULE6 - Lock asserts after the error stays in window for the qualify count.
// RULE7 - Qualify count is 14 bits, high six then low eight; zero invalid.
// RULE8 - Resistor four field bits 5:3, codes 0..4 valid, default 0.
// RULE9 - Resistor three field bits 2:0, same encoding, default 0.
// RULE10 - Each in-window comparison increments the lock counter; the counter here stops at 14'h3FFF.
// RULE11 - Software programs window width code 2 only.
// RULE12 - Software avoids reserved codes, zero count and set reserved bits.
//
// Register slice for the second loop: pump control, lock qualifier, filter.
// Assumes an AXI4-Lite master on aclk and an asynchronous sync request pin.
`timescale 1ns/100ps
module plr_regs
  import plr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [13:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [13:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sync_request_pin,
  input wire logic [1:0] frame_ref_source_sw,
  input wire logic compare_strobe,
  input wire logic phase_in_window,
  output logic [1:0] frame_ref_source_select,
  output plr_pump_type pump_cfg,
  output plr_filter_type filter_cfg,
  output logic [13:0] lock_qualify_count,
  output logic lock_detect,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  logic [7:0] pump_ctrl_q;
  logic [7:0] lock_high_q;
  logic [7:0] lock_low_q;
  logic [7:0] filter_res_q;
  logic [7:0] irq_status_q;
  logic [7:0] irq_mask_q;
  logic [13:0] aw_addr_q;
  logic aw_held_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic w_held_q;
  logic [7:0] irq_set_d;
  logic status_read_q;
  logic request_level;
  logic request_prev_q;
  logic locked;
  logic locked_prev_q;
  logic wr_fire;
  logic rd_fire;
  logic [11:0] wr_index;
  logic [11:0] rd_index;
  logic wr_hit;
  logic [7:0] wr_byte;
  logic [7:0] rd_byte;
  logic rd_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Submodules

  plr_pin_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(sync_request_pin),
    .level_q(request_level)
  );

  // Running count stays inside the qualifier
  plr_lock_detect u_lock (
    .aclk(aclk),
    .aresetn(aresetn),
    .compare_strobe(compare_strobe),
    .in_window(phase_in_window),
    .qualify_count({lock_high_q[5:0], lock_low_q}), // [RULE7]
    .locked_q(locked),
    .count_q()
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write channel

  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_index = plr_index(aw_addr_q);
  assign wr_byte = w_data_q[7:0];
  assign wr_hit = (wr_index == PLR_IDX_PUMP_CTRL) || (wr_index == PLR_IDX_LOCK_HIGH) ||
                  (wr_index == PLR_IDX_LOCK_LOW) || (wr_index == PLR_IDX_FILTER_RES) ||
                  (wr_index == PLR_IDX_IRQ_MASK);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 14'h0000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= PLR_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? PLR_RESP_OKAY : PLR_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  // Fixed bit 0 is kept by hardware; software is expected to write 1
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pump_ctrl_q <= PLR_RST_PUMP_CTRL; // [RULE1] [RULE2] [RULE3]
    end else if (wr_fire && w_strb_q[0] && wr_index == PLR_IDX_PUMP_CTRL) begin
      pump_ctrl_q <= (wr_byte & PLR_MASK_PUMP_CTRL & 8'hFE) | 8'h01; // [RULE3]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_high_q <= PLR_RST_LOCK_HIGH;
    end else if (wr_fire && w_strb_q[0] && wr_index == PLR_IDX_LOCK_HIGH) begin
      lock_high_q <= wr_byte & PLR_MASK_LOCK_HIGH; // [RULE7]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_low_q <= PLR_RST_LOCK_LOW;
    end else if (wr_fire && w_strb_q[0] && wr_index == PLR_IDX_LOCK_LOW) begin
      lock_low_q <= wr_byte & PLR_MASK_LOCK_LOW; // [RULE7]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filter_res_q <= PLR_RST_FILTER_RES; // [RULE8] [RULE9]
    end else if (wr_fire && w_strb_q[0] && wr_index == PLR_IDX_FILTER_RES) begin
      filter_res_q <= wr_byte & PLR_MASK_FILTER_RES; // [RULE8] [RULE9]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_q <= PLR_RST_IRQ_MASK;
    end else if (wr_fire && w_strb_q[0] && wr_index == PLR_IDX_IRQ_MASK) begin
      irq_mask_q <= wr_byte & PLR_MASK_IRQ;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs driven from registers

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pump_cfg <= '0;
      filter_cfg <= '0;
      lock_qualify_count <= 14'h0000;
    end else begin
      pump_cfg.window_width <= pump_ctrl_q[PLR_POS_WINDOW +: 2];
      pump_cfg.pump_gain <= pump_ctrl_q[PLR_POS_GAIN +: 2];
      pump_cfg.pump_polarity <= pump_ctrl_q[PLR_POS_POLARITY]; // [RULE1]
      pump_cfg.pump_float <= pump_ctrl_q[PLR_POS_FLOAT]; // [RULE2]
      filter_cfg.filter_res_four <= filter_res_q[PLR_POS_RES_FOUR +: 3]; // [RULE8]
      filter_cfg.filter_res_three <= filter_res_q[PLR_POS_RES_THREE +: 3]; // [RULE9]
      lock_qualify_count <= {lock_high_q[5:0], lock_low_q}; // [RULE7]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_ref_source_select <= 2'h0;
    end else if (lock_high_q[PLR_POS_REQ_EN] && request_level) begin
      frame_ref_source_select <= PLR_SRC_CONTINUOUS; // [RULE4]
    end else begin
      frame_ref_source_select <= frame_ref_source_sw;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_detect <= 1'b0;
    end else begin
      lock_detect <= locked; // [RULE6]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status; a set in the clearing cycle wins

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      locked_prev_q <= 1'b0;
      request_prev_q <= 1'b0;
    end else begin
      locked_prev_q <= locked;
      request_prev_q <= request_level;
    end
  end

  always_comb begin
    irq_set_d = 8'h00;
    irq_set_d[PLR_IRQ_LOCKED] = locked && !locked_prev_q;
    irq_set_d[PLR_IRQ_UNLOCKED] = !locked && locked_prev_q;
    irq_set_d[PLR_IRQ_REQUEST] = request_level && !request_prev_q && lock_high_q[PLR_POS_REQ_EN];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_q <= 8'h00;
    end else if (status_read_q) begin
      irq_status_q <= irq_set_d;
    end else begin
      irq_status_q <= irq_status_q | irq_set_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_q & irq_mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel

  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_index = plr_index(s_axi_araddr);

  always_comb begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    unique case (rd_index)
      PLR_IDX_PUMP_CTRL: rd_byte = pump_ctrl_q;
      PLR_IDX_LOCK_HIGH: rd_byte = lock_high_q;
      PLR_IDX_LOCK_LOW: rd_byte = lock_low_q;
      PLR_IDX_FILTER_RES: rd_byte = filter_res_q;
      PLR_IDX_IRQ_STATUS: rd_byte = irq_status_q;
      PLR_IDX_IRQ_MASK: rd_byte = irq_mask_q;
      PLR_IDX_LOCK_STATE: rd_byte = {7'h00, locked};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_read_q <= 1'b0;
    end else begin
      status_read_q <= rd_fire && (rd_index == PLR_IDX_IRQ_STATUS);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= PLR_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= rd_hit ? PLR_RESP_OKAY : PLR_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // plr_regs

/* plr_regs_monitor.sv */
// Checker for the second-loop pump, lock and filter register slice.
// Assumes it is bound to plr_regs and sees only its ports.
`timescale 1ns/100ps
module plr_regs_monitor
  import plr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic sync_request_pin,
  input wire logic [1:0] frame_ref_source_sw,
  input wire logic compare_strobe,
  input wire logic phase_in_window,
  input wire logic [1:0] frame_ref_source_select,
  input plr_pump_type pump_cfg,
  input plr_filter_type filter_cfg,
  input wire logic [13:0] lock_qualify_count,
  input wire logic lock_detect,
  input wire logic irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  AST_SRC_FORCE: assert property ($past(aresetn) &&
    frame_ref_source_select != $past(frame_ref_source_sw) |-> frame_ref_source_select == PLR_SRC_CONTINUOUS)
    else $error("source select neither software value nor continuous");
  AST_SRC_IDLE: assert property (!sync_request_pin [*8] |=>
    frame_ref_source_select == $past(frame_ref_source_sw))
    else $error("source select forced without request");
  AST_LOCK_RISE: assert property ($rose(lock_detect) |->
    $past(compare_strobe, 2) && $past(phase_in_window, 2))
    else $error("lock rose without in-window comparison");
  AST_LOCK_DROP: assert property (compare_strobe && !phase_in_window |-> ##2 !lock_detect)
    else $error("lock kept after out-of-window comparison");
  AST_PUMP_STABLE: assert property (!s_axi_wvalid [*3] |=> $stable(pump_cfg))
    else $error("pump config changed without write");
  AST_FILTER_STABLE: assert property (!s_axi_wvalid [*3] |=> $stable(filter_cfg))
    else $error("filter config changed without write");
  AST_COUNT_STABLE: assert property (!s_axi_wvalid [*3] |=> $stable(lock_qualify_count))
    else $error("qualify count changed without write");
  AST_RDATA_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  ////////////////////////////////////////
  COV_LOCK: cover property ($rose(lock_detect));
  COV_FORCE: cover property (frame_ref_source_select == PLR_SRC_CONTINUOUS);
  COV_IRQ: cover property ($rose(irq));
endmodule // plr_regs_monitor

/* pll2_pump_lock_filter_regs_tb.sv */
// Self-checking bench for the pump, lock and filter register slice.
// Assumes plr_regs with AXI4-Lite access and a 20 MHz aclk.
`timescale 1ns/100ps
module pll2_pump_lock_filter_regs_tb
  import plr_pkg::*;
;
  localparam logic [1:0] OK = PLR_RESP_OKAY;
  localparam logic [1:0] ERR = PLR_RESP_SLVERR;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [13:0] awaddr = 14'h0000, araddr = 14'h0000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic pin = 1'b0, stb = 1'b0, inw = 1'b0;
  logic [1:0] sw = 2'h0;
  logic awready, wready, bvalid, arready, rvalid, lock, irq;
  logic [1:0] bresp, rresp, src;
  logic [31:0] rdata;
  logic [13:0] cnt;
  plr_pump_type pump;
  plr_filter_type filt;
  int miscompares = 0;
  int n_checks = 0;
  always #25 aclk = ~aclk;
  plr_regs u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sync_request_pin(pin),
    .frame_ref_source_sw(sw), .compare_strobe(stb), .phase_in_window(inw), .frame_ref_source_select(src),
    .pump_cfg(pump), .filter_cfg(filt), .lock_qualify_count(cnt), .lock_detect(lock), .irq(irq));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] er);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
    @(posedge aclk);
  endtask
  task automatic rdc(input logic [11:0] idx, input logic [7:0] e, input logic [1:0] er);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk(rdata, {24'h000000, e});
    chk({30'h0, rresp}, {30'h0, er});
    @(posedge aclk);
  endtask
  task automatic pulse(input logic w);
    stb <= 1'b1;
    inw <= w;
    @(posedge aclk);
    stb <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    cyc(20000);
    miscompares++;
    end_sim();
  end
  initial begin
    cyc(4);
    aresetn <= 1'b1;
    cyc(2);
    rdc(PLR_IDX_PUMP_CTRL, 8'h59, OK);
    rdc(PLR_IDX_LOCK_HIGH, 8'h20, OK);
    rdc(PLR_IDX_LOCK_LOW, 8'h00, OK);
    rdc(PLR_IDX_FILTER_RES, 8'h00, OK);
    chk({26'h0, pump}, 32'h2C);
    chk({18'h0, cnt}, 32'h2000);
    $display("test reset done");
    wr(PLR_IDX_PUMP_CTRL, 8'h45, OK);
    rdc(PLR_IDX_PUMP_CTRL, 8'h45, OK);
    chk({26'h0, pump}, 32'h22);
    wr(PLR_IDX_PUMP_CTRL, 8'h43, OK);
    rdc(PLR_IDX_PUMP_CTRL, 8'h43, OK);
    chk({26'h0, pump}, 32'h21);
    $display("test pump done");
    for (int i = 0; i < 5; i++) begin
      wr(PLR_IDX_FILTER_RES, {2'b00, 3'(i), 3'(4 - i)}, OK);
      rdc(PLR_IDX_FILTER_RES, {2'b00, 3'(i), 3'(4 - i)}, OK);
      chk({26'h0, filt}, {26'h0, 3'(i), 3'(4 - i)});
    end
    wr(PLR_IDX_FILTER_RES, 8'h00, OK);
    rdc(PLR_IDX_FILTER_RES, 8'h00, OK);
    $display("test filter done");
    wr(PLR_IDX_IRQ_MASK, 8'h03, OK);
    wr(PLR_IDX_LOCK_LOW, 8'h03, OK);
    wr(PLR_IDX_LOCK_HIGH, 8'h00, OK);
    chk({18'h0, cnt}, 32'h3);
    pulse(1'b1);
    pulse(1'b1);
    pulse(1'b0);
    pulse(1'b1);
    pulse(1'b1);
    cyc(4);
    chk({31'h0, lock}, 32'h0);
    pulse(1'b1);
    cyc(3);
    chk({31'h0, lock}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rdc(PLR_IDX_LOCK_STATE, 8'h01, OK);
    rdc(PLR_IDX_IRQ_STATUS, 8'h01, OK);
    cyc(3);
    chk({31'h0, irq}, 32'h0);
    pulse(1'b0);
    cyc(3);
    chk({31'h0, lock}, 32'h0);
    rdc(PLR_IDX_IRQ_STATUS, 8'h02, OK);
    rdc(PLR_IDX_LOCK_STATE, 8'h00, OK);
    wr(PLR_IDX_LOCK_HIGH, 8'h3F, OK);
    wr(PLR_IDX_LOCK_LOW, 8'hFF, OK);
    chk({18'h0, cnt}, 32'h3FFF);
    $display("test lock done");
    sw <= PLR_SRC_PULSER;
    wr(PLR_IDX_LOCK_HIGH, 8'h7F, OK);
    rdc(PLR_IDX_LOCK_HIGH, 8'h7F, OK);
    pin <= 1'b1;
    cyc(8);
    chk({30'h0, src}, {30'h0, PLR_SRC_CONTINUOUS});
    chk({31'h0, irq}, 32'h0);
    rdc(PLR_IDX_IRQ_STATUS, 8'h04, OK);
    pin <= 1'b0;
    cyc(8);
    chk({30'h0, src}, {30'h0, PLR_SRC_PULSER});
    wr(PLR_IDX_LOCK_HIGH, 8'h3F, OK);
    pin <= 1'b1;
    cyc(8);
    chk({30'h0, src}, {30'h0, PLR_SRC_PULSER});
    pin <= 1'b0;
    $display("test request done");
    rdc(12'h100, 8'h00, ERR);
    wr(PLR_IDX_IRQ_STATUS, 8'h01, ERR);
    $display("test unmapped done");
    end_sim();
  end
endmodule // pll2_pump_lock_filter_regs_tb

bind plr_regs plr_regs_monitor u_mon (.aclk(aclk), .aresetn(aresetn), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata), .sync_request_pin(sync_request_pin),
  .frame_ref_source_sw(frame_ref_source_sw), .compare_strobe(compare_strobe), .phase_in_window(phase_in_window),
  .frame_ref_source_select(frame_ref_source_select), .pump_cfg(pump_cfg), .filter_cfg(filter_cfg),
  .lock_qualify_count(lock_qualify_count), .lock_detect(lock_detect), .irq(irq));
